// ===== core/eprom_access_guard.sv
// EPROM access guard: security levels, runtime protection, memory enables
//
// The AHB-Lite slave port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "eprom_guard_defs.svh"

module eprom_access_guard
  import eprom_guard_pkg::*;
#(
  parameter int ROM_AW = 14
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Mode pins
  input wire logic external_memory_select,
  input wire logic eprom_mode,
  input wire logic extended_address_enable,
  // Core side
  input wire core_req_t core_req,
  input wire logic [7:0] core_rom_rdata,
  output logic [7:0] core_rdata,
  output logic core_rvalid,
  output logic core_illegal,
  output logic core_external,
  // Programmer side
  input wire prog_req_t prog_req,
  input wire logic [7:0] prog_rom_rdata,
  output logic [7:0] prog_rdata,
  output logic prog_rvalid,
  output logic prog_refused,
  // EPROM array write port
  output logic rom_we,
  output logic [ROM_AW-1:0] rom_waddr,
  output logic [7:0] rom_wdata,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [11:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp
);

  // Configuration bytes: level bits and memory_config_byte
  logic [1:0] level_reg;
  logic [1:0] memory_config_byte_reg;
  logic ext_mem_reg;
  logic ext_mem_pending_reg;
  logic opcode_in_eprom_reg;
  logic [7:0] viol_count_reg;
  logic [7:0] prog_count_reg;
  logic [7:0] core_rdata_reg;
  logic core_rvalid_reg;
  logic core_illegal_reg;
  logic core_external_reg;
  logic [7:0] prog_rdata_reg;
  logic prog_rvalid_reg;
  logic prog_refused_reg;
  logic rom_we_reg;
  logic [ROM_AW-1:0] rom_waddr_reg;
  logic [7:0] rom_wdata_reg;
  logic [31:0] hrdata_reg;
  logic ahb_wr_pend_reg;
  logic ahb_rd_pend_reg;
  logic [11:0] ahb_addr_reg;

  region_t core_region;
  logic region_illegal;
  logic prog_allowed;
  logic read_protected;
  logic operand_blocked;

  function automatic logic [7:0] crypt(input logic [7:0] d, input logic [ROM_AW-1:0] a);
    crypt = d ^ `CRYPT_KEY ^ a[7:0];
  endfunction

  region_decoder u_region (
    .addr(core_req.addr),
    .rom_low_en(memory_config_byte_reg[`CFG_ROM_BIT]),
    .ram_high_en(memory_config_byte_reg[`CFG_RAM_BIT]),
    .ext_mem(ext_mem_reg),
    .ext_addr_en(extended_address_enable),
    .region(core_region),
    .illegal(region_illegal)
  );

  // Only level 3 may program
  assign prog_allowed = (level_reg == 2'h3);
  assign read_protected = (level_reg == 2'h1) || (level_reg == 2'h0);
  // Operand reads of EPROM by foreign opcodes are blocked at levels 0 and 1
  assign operand_blocked = read_protected && !opcode_in_eprom_reg;

  // External pin captured at reset release
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_mem_pending_reg <= 1'b1;
      ext_mem_reg <= 1'b0;
    end else if (ext_mem_pending_reg) begin
      ext_mem_pending_reg <= 1'b0;
      ext_mem_reg <= external_memory_select;
    end
  end

  // Opcode source flag; updated on every opcode fetch outside EPROM mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      opcode_in_eprom_reg <= 1'b1;
    end else if (!eprom_mode && core_req.valid && core_req.kind == ACC_FETCH) begin
      opcode_in_eprom_reg <= (core_region == SRC_EPROM);
    end
  end

  // Core read path
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      core_rdata_reg <= 8'h00;
      core_rvalid_reg <= 1'b0;
      core_illegal_reg <= 1'b0;
      core_external_reg <= 1'b0;
    end else begin
      core_rvalid_reg <= 1'b0;
      core_illegal_reg <= 1'b0;
      core_external_reg <= 1'b0;
      if (!eprom_mode && core_req.valid) begin
        core_illegal_reg <= region_illegal;
        core_external_reg <= (core_region == SRC_EXTERNAL);
        if (core_region == SRC_EPROM && core_req.kind != ACC_WRITE) begin
          core_rvalid_reg <= 1'b1;
          if (core_req.kind == ACC_OPERAND && operand_blocked) begin
            core_rdata_reg <= `BLOCKED_BYTE;
          end else begin
            core_rdata_reg <= core_rom_rdata;
          end
        end
      end
    end
  end

  // Violation counter for software visibility
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      viol_count_reg <= 8'h00;
    end else if (!eprom_mode && core_req.valid && core_region == SRC_EPROM
                 && core_req.kind == ACC_OPERAND && operand_blocked
                 && viol_count_reg != 8'hFF) begin
      viol_count_reg <= viol_count_reg + 8'h01;
    end
  end

  // Programmer path, only in EPROM mode
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prog_rdata_reg <= 8'h00;
      prog_rvalid_reg <= 1'b0;
      prog_refused_reg <= 1'b0;
      rom_we_reg <= 1'b0;
      rom_waddr_reg <= '0;
      rom_wdata_reg <= 8'h00;
    end else begin
      prog_rvalid_reg <= 1'b0;
      prog_refused_reg <= 1'b0;
      rom_we_reg <= 1'b0;
      if (eprom_mode && prog_req.valid) begin
        if (prog_req.write) begin
          if (!prog_allowed) begin
            prog_refused_reg <= 1'b1;
          end else if (!prog_req.config_sel) begin
            rom_we_reg <= 1'b1;
            rom_waddr_reg <= prog_req.addr[ROM_AW-1:0];
            rom_wdata_reg <= prog_req.wdata;
          end
        end else begin
          prog_rvalid_reg <= 1'b1;
          if (prog_req.config_sel) begin
            prog_rdata_reg <= {4'h0, memory_config_byte_reg, level_reg};
          end else if (level_reg == 2'h0) begin
            prog_rdata_reg <= `BLOCKED_BYTE;
            prog_refused_reg <= 1'b1;
          end else if (level_reg == 2'h1) begin
            prog_rdata_reg <= crypt(prog_rom_rdata, prog_req.addr[ROM_AW-1:0]);
          end else begin
            prog_rdata_reg <= prog_rom_rdata;
          end
        end
      end
    end
  end

  // Configuration bytes; writes only take EPROM bits from 1 to 0, reset sets them back to 1
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      level_reg <= `LEVEL_RESET;
      memory_config_byte_reg <= `MEMCFG_RESET;
    end else if (eprom_mode && prog_req.valid && prog_req.write
                 && prog_req.config_sel && prog_allowed) begin
      level_reg <= level_reg & prog_req.wdata[1:0];
      memory_config_byte_reg <= memory_config_byte_reg & prog_req.wdata[3:2];
    end
  end

  // Programming counter
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      prog_count_reg <= 8'h00;
    end else if (rom_we_reg && prog_count_reg != 8'hFF) begin
      prog_count_reg <= prog_count_reg + 8'h01;
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ahb_wr_pend_reg <= 1'b0;
      ahb_rd_pend_reg <= 1'b0;
      ahb_addr_reg <= 12'h000;
    end else if (hready) begin
      ahb_wr_pend_reg <= hsel && htrans[1] && hwrite;
      ahb_rd_pend_reg <= hsel && htrans[1] && !hwrite;
      ahb_addr_reg <= haddr;
    end
  end

  // Read data registered at address phase
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (hready && hsel && htrans[1] && !hwrite) begin
      if (haddr == `REG_LEVEL) begin
        hrdata_reg <= {30'h0, level_reg};
      end else if (haddr == `REG_MEMCFG) begin
        hrdata_reg <= {30'h0, memory_config_byte_reg};
      end else if (haddr == `REG_STATUS) begin
        hrdata_reg <= {28'h0, eprom_mode, ext_mem_reg, opcode_in_eprom_reg, read_protected};
      end else if (haddr == `REG_VIOL) begin
        hrdata_reg <= {24'h0, viol_count_reg};
      end else if (haddr == `REG_PROG) begin
        hrdata_reg <= {24'h0, prog_count_reg};
      end else begin
        hrdata_reg <= 32'h0000_0000;
      end
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign core_rdata = core_rdata_reg;
  assign core_rvalid = core_rvalid_reg;
  assign core_illegal = core_illegal_reg;
  assign core_external = core_external_reg;
  assign prog_rdata = prog_rdata_reg;
  assign prog_rvalid = prog_rvalid_reg;
  assign prog_refused = prog_refused_reg;
  assign rom_we = rom_we_reg;
  assign rom_waddr = rom_waddr_reg;
  assign rom_wdata = rom_wdata_reg;

endmodule
`default_nettype wire

// ===== core/region_decoder.sv
// Address region decoder for core accesses
`timescale 1ns/1ps
`default_nettype none
`include "eprom_guard_defs.svh"

module region_decoder
  import eprom_guard_pkg::*;
(
  // Access
  input wire logic [15:0] addr,
  // Configuration
  input wire logic rom_low_en,
  input wire logic ram_high_en,
  input wire logic ext_mem,
  input wire logic ext_addr_en,
  // Result
  output region_t region,
  output logic illegal
);

  always_comb begin
    region = SRC_NONE;
    illegal = 1'b0;
    if (addr <= `RAM_LOW_LAST) begin
      region = SRC_RAM;
    end else if (addr >= `RAM_HIGH_FIRST && addr <= `RAM_HIGH_LAST) begin
      // Upper RAM block (0x0200-0x02FF, a third of the RAM) gated by configuration
      if (ram_high_en) begin
        region = SRC_RAM;
      end else begin
        region = ext_addr_en ? SRC_EXTERNAL : SRC_NONE;
        illegal = !ext_addr_en;
      end
    end else if (addr >= `ROM_LOW_FIRST) begin
      // Pin routes the whole EPROM range off chip
      if (ext_mem) begin
        region = SRC_EXTERNAL;
      end else if (addr >= `ROM_HIGH_FIRST || rom_low_en) begin
        region = SRC_EPROM;
      end else begin
        region = ext_addr_en ? SRC_EXTERNAL : SRC_NONE;
        illegal = !ext_addr_en;
      end
    end else begin
      region = ext_addr_en ? SRC_EXTERNAL : SRC_NONE;
      illegal = !ext_addr_en;
    end
  end

endmodule
`default_nettype wire

// ===== include/eprom_guard_defs.svh
// Constants for the EPROM access guard
`ifndef EPROM_GUARD_DEFS_SVH
`define EPROM_GUARD_DEFS_SVH

`define REG_LEVEL 12'h000
`define REG_MEMCFG 12'h004
`define REG_STATUS 12'h008
`define REG_VIOL 12'h00C
`define REG_PROG 12'h010

`define CFG_ROM_BIT 0
`define CFG_RAM_BIT 1
`define LEVEL_RESET 2'h3
`define MEMCFG_RESET 2'h3
`define BLOCKED_BYTE 8'hFF
`define CRYPT_KEY 8'hA5

`define RAM_LOW_LAST 16'h01FF
`define RAM_HIGH_FIRST 16'h0200
`define RAM_HIGH_LAST 16'h02FF
`define ROM_LOW_FIRST 16'hC000
`define ROM_LOW_LAST 16'hDFFF
`define ROM_HIGH_FIRST 16'hE000

`endif

// ===== include/eprom_guard_pkg.sv
// Types for the EPROM access guard
package eprom_guard_pkg;

  typedef enum logic [1:0] {
    SRC_EPROM = 2'b00,
    SRC_RAM = 2'b01,
    SRC_EXTERNAL = 2'b10,
    SRC_NONE = 2'b11
  } region_t;

  typedef enum logic [1:0] {
    ACC_FETCH = 2'b00,
    ACC_OPERAND = 2'b01,
    ACC_VECTOR = 2'b10,
    ACC_WRITE = 2'b11
  } access_kind_t;

  typedef struct packed {
    logic valid;
    access_kind_t kind;
    logic [15:0] addr;
    logic [7:0] wdata;
  } core_req_t;

  typedef struct packed {
    logic valid;
    logic write;
    logic config_sel;
    logic [13:0] addr;
    logic [7:0] wdata;
  } prog_req_t;

  typedef struct packed {
    logic rom_on;
    logic ram_on;
    logic external;
    logic error;
  } route_t;

endpackage

// ===== tb/eprom_access_guard_asserts.sv
// Port checks for the EPROM access guard
`timescale 1ns/1ps
`default_nettype none
`include "eprom_guard_defs.svh"
module eprom_access_guard_asserts
  import eprom_guard_pkg::*;
#(
  parameter int ROM_AW = 14
)
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Mode
  input wire logic external_memory_select,
  input wire logic eprom_mode,
  // Core side
  input wire core_req_t core_req,
  input wire logic [7:0] core_rom_rdata,
  input wire logic [7:0] core_rdata,
  input wire logic core_rvalid,
  // Programmer side
  input wire prog_req_t prog_req,
  input wire logic [7:0] prog_rom_rdata,
  input wire logic [7:0] prog_rdata,
  input wire logic prog_rvalid,
  input wire logic prog_refused,
  input wire logic rom_we,
  input wire logic [ROM_AW-1:0] rom_waddr,
  input wire logic [7:0] rom_wdata
);
  logic armed;
  logic ext_q;
  logic [1:0] lvl;
  wire logic pv = eprom_mode && prog_req.valid;
  wire logic rd = pv && !prog_req.write && !prog_req.config_sel;
  wire logic on_rom = !eprom_mode && !ext_q && core_req.valid && core_req.addr >= 16'hE000;
  always_ff @(posedge clk_sys) armed <= !rst_n;
  always_ff @(posedge clk_sys) if (armed && rst_n) ext_q <= external_memory_select;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) lvl <= `LEVEL_RESET;
    else if (pv && prog_req.write && prog_req.config_sel && lvl == 2'h3)
      lvl <= lvl & prog_req.wdata[1:0];
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  sequence echo_rom;
    core_rvalid && core_rdata == $past(core_rom_rdata);
  endsequence
  AST_VECTOR_PASS: assert property (on_rom && core_req.kind == ACC_VECTOR |=> echo_rom)
    else $error("vector altered");
  AST_FETCH_PASS: assert property (on_rom && core_req.kind == ACC_FETCH |=> echo_rom)
    else $error("fetch altered");
  AST_WRITE_BLOCKED: assert property (
    pv && prog_req.write && lvl != 2'h3 |=> prog_refused && !rom_we)
    else $error("write not refused");
  AST_WRITE_DONE: assert property (
    pv && prog_req.write && !prog_req.config_sel && lvl == 2'h3 |=> rom_we &&
    rom_waddr == $past(prog_req.addr) && rom_wdata == $past(prog_req.wdata))
    else $error("write lost");
  AST_LEVEL0_READ: assert property (
    rd && lvl == 2'h0 |=> prog_rvalid && prog_refused && prog_rdata == `BLOCKED_BYTE)
    else $error("level 0 read open");
  AST_LEVEL1_READ: assert property (
    rd && lvl == 2'h1 |=> prog_rvalid &&
    prog_rdata == ($past(prog_rom_rdata) ^ `CRYPT_KEY ^ $past(prog_req.addr[7:0])))
    else $error("level 1 read plain");
  AST_CONFIG_READ: assert property (
    pv && !prog_req.write && prog_req.config_sel |=> prog_rvalid && prog_rdata[1:0] == $past(lvl))
    else $error("config read wrong");
  AST_CORE_SHUT: assert property (eprom_mode |=> !core_rvalid)
    else $error("core answered in programmer mode");
endmodule
`default_nettype wire

// ===== tb/rom_model.sv
// EPROM array model behind the guard
`timescale 1ns/1ps
`default_nettype none
module rom_model
  import eprom_guard_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Requests
  input wire core_req_t core_req,
  input wire prog_req_t prog_req,
  // Read data
  output logic [7:0] core_rom_rdata,
  output logic [7:0] prog_rom_rdata,
  // Program port
  input wire logic rom_we,
  input wire logic [13:0] rom_waddr,
  input wire logic [7:0] rom_wdata
);
  logic [7:0] mem [16384];
  initial for (int i = 0; i < 16384; i++) mem[i] = i[7:0] ^ 8'h3C;
  // Programming only clears bits
  always @(posedge clk_sys) if (rom_we) mem[rom_waddr] <= mem[rom_waddr] & rom_wdata;
  // Idle reads show inverted data
  assign core_rom_rdata = {8{~core_req.valid}} ^ mem[core_req.addr[13:0]];
  assign prog_rom_rdata = {8{~prog_req.valid}} ^ mem[prog_req.addr];
endmodule
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the EPROM access guard
`timescale 1ns/1ps
`default_nettype none
module testbench
  import eprom_guard_pkg::*;
;
  logic clk_sys, rst_n, external_memory_select, eprom_mode, extended_address_enable;
  core_req_t core_req;
  prog_req_t prog_req;
  logic [7:0] core_rom_rdata, prog_rom_rdata, core_rdata, prog_rdata, rom_wdata;
  logic core_rvalid, core_illegal, core_external, prog_rvalid, prog_refused, rom_we;
  logic [13:0] rom_waddr;
  logic hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata;
  wire hready = hreadyout;
  int mismatches, samples_checked;
  eprom_access_guard eprom_access_guard_inst (.*);
  rom_model rom_model_inst (.*);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("compared %0d, mismatched %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic do_reset(input logic pin);
    rst_n <= 1'b0;
    external_memory_select <= pin;
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic core(input access_kind_t k, input logic [15:0] a);
    core_req <= '{1'b1, k, a, 8'h00};
    @(posedge clk_sys);
    core_req.valid <= 1'b0;
    #1;
  endtask
  task automatic prog(input logic w, input logic c, input logic [13:0] a, input logic [7:0] d);
    prog_req <= '{1'b1, w, c, a, d};
    @(posedge clk_sys);
    prog_req.valid <= 1'b0;
    #1;
  endtask
  task automatic hwait();
    for (int n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (hready === 1'b1) return;
    end
    mismatches++;
    give_verdict();
  endtask
  task automatic ahb_rd(input logic [11:0] a, input logic [31:0] e);
    @(posedge clk_sys);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwait();
    htrans <= 2'h0;
    hwait();
    chk(hrdata, e);
    chk({hreadyout, hresp}, 2'b10);
  endtask
  task automatic t_open_run();
    ahb_rd(12'h000, 32'h3);
    ahb_rd(12'h004, 32'h3);
    ahb_rd(12'h020, 32'h0);
    core(ACC_FETCH, 16'h0010);
    core(ACC_OPERAND, 16'hE020);
    chk({core_rvalid, core_rdata}, 9'h11C);
    core(ACC_FETCH, 16'h0400);
    chk(core_illegal, 1'b1);
    core(ACC_OPERAND, 16'h0250);
    chk(core_illegal, 1'b0);
    core(ACC_FETCH, 16'hC010);
    chk({core_rvalid, core_rdata}, 9'h12C);
    extended_address_enable <= 1'b1;
    core(ACC_FETCH, 16'h0400);
    chk(core_external, 1'b1);
    extended_address_enable <= 1'b0;
  endtask
  task automatic t_lock(input logic [7:0] cfg);
    eprom_mode <= 1'b1;
    prog(1'b1, 1'b0, 14'h0005, 8'h0F);
    chk({rom_we, rom_waddr, rom_wdata}, {1'b1, 14'h0005, 8'h0F});
    prog(1'b0, 1'b1, 14'h0000, 8'h00);
    chk({prog_rvalid, prog_rdata}, 9'h10F);
    prog(1'b1, 1'b1, 14'h0000, cfg);
    prog(1'b1, 1'b0, 14'h0006, 8'h00);
    chk({prog_refused, rom_we}, 2'b10);
    prog(1'b1, 1'b1, 14'h0000, 8'h00);
    chk({prog_refused, rom_we}, 2'b10);
    prog(1'b0, 1'b1, 14'h0000, 8'h00);
    chk(prog_rdata, cfg);
    prog(1'b0, 1'b0, 14'h0033, 8'h00);
    chk(prog_rdata, cfg[0] ? 8'h99 : 8'hFF);
    eprom_mode <= 1'b0;
  endtask
  task automatic t_protect(input logic [1:0] lv);
    core(ACC_FETCH, 16'h0010);
    core(ACC_OPERAND, 16'hE020);
    chk({core_rvalid, core_rdata}, 9'h1FF);
    core(ACC_VECTOR, 16'hFFFE);
    chk(core_rdata, 8'hC2);
    core(ACC_FETCH, 16'hE000);
    chk(core_rdata, 8'h3C);
    core(ACC_OPERAND, 16'hE020);
    chk(core_rdata, 8'h1C);
    core(ACC_FETCH, 16'hC010);
    chk(core_illegal, 1'b1);
    core(ACC_OPERAND, 16'h0250);
    chk(core_illegal, 1'b1);
    ahb_rd(12'h000, {30'h0, lv});
    ahb_rd(12'h004, 32'h0);
    ahb_rd(12'h008, 32'h1);
    ahb_rd(12'h00C, 32'h1);
    ahb_rd(12'h010, 32'h1);
  endtask
  initial begin
    mismatches = 0;
    samples_checked = 0;
    rst_n = 1'b0;
    external_memory_select = 1'b0;
    eprom_mode = 1'b0;
    extended_address_enable = 1'b0;
    core_req = '0;
    prog_req = '0;
    hsel = 1'b0;
    haddr = 12'h000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    do_reset(1'b0);
    t_open_run();
    t_lock(8'h01);
    t_protect(2'h1);
    do_reset(1'b0);
    t_lock(8'h00);
    t_protect(2'h0);
    do_reset(1'b1);
    external_memory_select <= 1'b0;
    core(ACC_FETCH, 16'hE010);
    chk({core_external, core_rvalid}, 2'b10);
    ahb_rd(12'h008, 32'h4);
    give_verdict();
  end
endmodule
bind eprom_access_guard eprom_access_guard_asserts #(.ROM_AW(ROM_AW))
  eprom_access_guard_asserts_inst (.*);
`default_nettype wire
